// ### hw/fac_pkg.sv
package fac_pkg;
    // first section: divide by 2 then feedback pair giving /3 overall /6
    localparam int unsigned STAGE_A_DIV = 6;
    // two plain binary halvings, 192 kHz to 48 kHz
    localparam int unsigned STAGE_B_DIV = 4;
    // final section: /6 down to 8 kHz
    localparam int unsigned STAGE_C_DIV = 6;
    localparam logic [2:0] CNT6_RST = 3'h0;
    localparam logic [1:0] CNT4_RST = 2'h0;
    localparam logic [2:0] CNT6_LAST = 3'h5;
    localparam logic [1:0] CNT4_LAST = 2'h3;
    // feedback fires when the three tapped stages all read this pattern
    localparam logic [2:0] FB_PATTERN = 3'h7;
    // bit index of each output in the top counter
    localparam int unsigned ADDR_BIT = 2;
endpackage

// ### hw/fac_div6.sv
`timescale 1ns/10ps
// divide-by-six section: a toggle stage then a two-stage pair whose
// feedback gate forces an extra toggle of the middle stage
module fac_div6 (
    input wire logic clk_sys, // system clock
    input wire logic resetn, // synchronous reset, active low
    input wire logic clear, // hold at zero
    input wire logic stepIn, // one-cycle input pulse
    output logic stepOut, // one pulse per six inputs
    output logic [2:0] state // stage values for observation
);
    logic q1_ff, q2_ff, q3_ff;
    logic nxt_q1, nxt_q2, nxt_q3;
    wire logic fbHit;
    wire logic fall1;
    wire logic fall2;
    wire logic flip2;
    // stage 1 falls (1->0) on every second input
    assign fall1 = stepIn && q1_ff;
    // feedback: stage 1 about to rise while stages 2 and 3 are both high
    assign fbHit = stepIn &&
                   ({~q1_ff, q2_ff, q3_ff} == fac_pkg::FB_PATTERN);
    // the extra kick lands between stage-1 falls, so stage 3 becomes a
    // square wave of six inputs instead of eight
    assign flip2 = fall1 || fbHit;
    assign fall2 = flip2 && q2_ff;
    always_comb
    begin
        nxt_q1 = q1_ff ^ stepIn;
        nxt_q2 = q2_ff ^ flip2;
        nxt_q3 = q3_ff ^ fall2;
    end
    always_ff @(posedge clk_sys)
    begin
        if (!resetn || clear)
        begin
            q1_ff <= 1'b0;
            q2_ff <= 1'b0;
            q3_ff <= 1'b0;
        end
        else
        begin
            q1_ff <= nxt_q1;
            q2_ff <= nxt_q2;
            q3_ff <= nxt_q3;
        end
    end
    assign stepOut = fbHit;
    assign state = {q3_ff, q2_ff, q1_ff};
endmodule // fac_div6

// ### hw/fac_frame_address_countdown.sv
`timescale 1ns/10ps
module fac_frame_address_countdown (
    input wire logic clk_sys, // system clock, 25 MHz
    input wire logic resetn, // synchronous reset, active low
    input wire logic countdownPulse, // base-rate pulse, one cycle
    input wire logic skipRequest, // skip pulse, one cycle
    input wire logic addressSeparationMode, // separation mode level
    input wire logic timingOneCtl, // timing-1 control square wave
    input wire logic timingTwoCtl, // timing-2 control square wave
    output logic controlPulse, // doubled-rate control pulse
    output logic trafficTimingOne, // medium-traffic timing-1 wave
    output logic trafficTimingTwo, // medium-traffic timing-2 wave
    output logic timingOutOne, // shaped timing-1 pulse
    output logic samplePhaseA, // sampling phase A pulse
    output logic timingOutTwo, // shaped timing-2 pulse
    output logic samplePhaseB, // sampling phase B pulse
    output logic frameAddressOne, // 8 kHz address-1
    output logic frameAddressTwo // 8 kHz address-2
);
    // all async pins pass two flops before use
    logic [4:0] syncA_ff, syncB_ff;
    logic [4:0] nxt_syncA, nxt_syncB;
    logic cdLast_ff, t1Last_ff, t2Last_ff;
    logic [5:0] gap_ff, halfCnt_ff;
    logic [5:0] nxt_gap, nxt_halfCnt;
    logic echoPend_ff, nxt_echoPend;
    logic inhibit_ff, nxt_inhibit;
    logic half_ff, nxt_half;
    logic [1:0] mid_ff, nxt_mid;
    logic ctl_ff, tra1_ff, tra2_ff, to1_ff, pa_ff, to2_ff, pb_ff;
    logic adr1_ff, adr2_ff;
    wire logic cdIn, skipIn, modeIn, t1In, t2In;
    wire logic cdRise, t1Rise, t2Rise;
    wire logic echoFire, rawPulse, passPulse, midWrap;
    wire logic stepC, stepD;
    wire logic [2:0] stA, stD;
    wire logic idle;

    assign nxt_syncA = {timingTwoCtl, timingOneCtl, addressSeparationMode,
                        skipRequest, countdownPulse};
    assign nxt_syncB = syncA_ff;
    assign {t2In, t1In, modeIn, skipIn, cdIn} = syncB_ff;
    assign idle = !modeIn;
    assign cdRise = cdIn && !cdLast_ff;
    assign t1Rise = t1In && !t1Last_ff;
    assign t2Rise = t2In && !t2Last_ff;

    // echo lands half the measured input period later
    assign echoFire = echoPend_ff && (halfCnt_ff == gap_ff[5:0] >> 1);
    assign rawPulse = cdRise || echoFire;
    // a skip held in inhibit swallows exactly one doubled pulse
    assign passPulse = rawPulse && !inhibit_ff && !idle;
    assign nxt_gap = cdRise ? halfCnt_ff : gap_ff;
    assign nxt_halfCnt = cdRise ? 6'h0 :
                         (halfCnt_ff == 6'h3f ? halfCnt_ff : halfCnt_ff + 6'h1);
    assign nxt_echoPend = cdRise ? 1'b1 : (echoFire ? 1'b0 : echoPend_ff);
    // set wins when a skip lands on the clearing pulse
    assign nxt_inhibit = idle ? 1'b0 :
                         ((skipIn && modeIn) ? 1'b1 :
                         (rawPulse ? 1'b0 : inhibit_ff));
    assign nxt_half = half_ff ^ passPulse;
    assign midWrap = stepC && (mid_ff == fac_pkg::CNT4_LAST);
    assign nxt_mid = stepC ? mid_ff + 2'h1 : mid_ff;

    fac_div6 uDivA (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .clear(idle),
        .stepIn(passPulse),
        .stepOut(stepC),
        .state(stA)
    );
    fac_div6 uDivC (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .clear(idle),
        .stepIn(midWrap),
        .stepOut(stepD),
        .state(stD)
    );

    always_ff @(posedge clk_sys)
    begin
        syncA_ff <= nxt_syncA;
        syncB_ff <= nxt_syncB;
        if (!resetn)
        begin
            cdLast_ff <= 1'b0;
            t1Last_ff <= 1'b0;
            t2Last_ff <= 1'b0;
            gap_ff <= 6'h0;
            halfCnt_ff <= 6'h0;
            echoPend_ff <= 1'b0;
            inhibit_ff <= 1'b0;
            half_ff <= 1'b0;
            mid_ff <= fac_pkg::CNT4_RST;
        end
        else
        begin
            cdLast_ff <= cdIn;
            t1Last_ff <= t1In;
            t2Last_ff <= t2In;
            gap_ff <= nxt_gap;
            halfCnt_ff <= nxt_halfCnt;
            echoPend_ff <= nxt_echoPend;
            inhibit_ff <= nxt_inhibit;
            half_ff <= idle ? 1'b0 : nxt_half;
            mid_ff <= idle ? fac_pkg::CNT4_RST : nxt_mid;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            ctl_ff <= 1'b0;
            tra1_ff <= 1'b0;
            tra2_ff <= 1'b1;
            to1_ff <= 1'b0;
            pa_ff <= 1'b0;
            to2_ff <= 1'b0;
            pb_ff <= 1'b0;
            adr1_ff <= 1'b0;
            adr2_ff <= 1'b1;
        end
        else
        begin
            ctl_ff <= passPulse;
            tra1_ff <= half_ff;
            tra2_ff <= !half_ff;
            to1_ff <= t1Rise;
            pa_ff <= t1Rise;
            to2_ff <= t2Rise;
            pb_ff <= t2Rise;
            adr1_ff <= stD[fac_pkg::ADDR_BIT];
            adr2_ff <= !stD[fac_pkg::ADDR_BIT];
        end
    end

    assign controlPulse = ctl_ff;
    assign trafficTimingOne = tra1_ff;
    assign trafficTimingTwo = tra2_ff;
    assign timingOutOne = to1_ff;
    assign samplePhaseA = pa_ff;
    assign timingOutTwo = to2_ff;
    assign samplePhaseB = pb_ff;
    assign frameAddressOne = adr1_ff;
    assign frameAddressTwo = adr2_ff;

    skip_clear_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        (inhibit_ff && rawPulse && !(skipIn && modeIn)) |=> !inhibit_ff)
        else $error("inhibit not cleared by next pulse");
    skip_swallow_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        (inhibit_ff && rawPulse) |=> !controlPulse)
        else $error("inhibited pulse passed");
    idle_zero_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        idle |=> (mid_ff == 2'h0 && !inhibit_ff && !half_ff))
        else $error("countdown not held idle");
    ctl_follow_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        passPulse |=> controlPulse)
        else $error("control pulse missing");
    trafic_comp_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        trafficTimingOne != trafficTimingTwo)
        else $error("timing waves not complementary");
    addr_comp_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        frameAddressOne != frameAddressTwo)
        else $error("address outputs not complementary");
    phase_a_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        timingOutOne == samplePhaseA)
        else $error("phase A differs from timing-out-1");
    out_one_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        t1Rise |=> timingOutOne ##1 !timingOutOne)
        else $error("timing-out-1 not a one-cycle pulse");
    out_two_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        t2Rise |=> (timingOutTwo && samplePhaseB))
        else $error("timing-2 path missing pulse");
    mid_step_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        (stepC && !idle) |=> mid_ff == $past(mid_ff) + 2'h1)
        else $error("halving stages did not advance");

    // an input pulse is taken; its echo must follow within half the
    // longest period that the gap counter can measure
    sequence pulseTakenS;
        cdRise;
    endsequence
    sequence echoDueS;
        ##[1:32] echoFire;
    endsequence
    echo_due_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        pulseTakenS |-> echoDueS)
        else $error("echo pulse missing");
    // a skip taken in separation mode is held until a pulse uses it
    sequence skipTakenS;
        skipIn && modeIn;
    endsequence
    skip_set_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        skipTakenS |=> inhibit_ff)
        else $error("skip request not held");
    // one output of the first section restarts its six-state cycle
    div_cycle_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        stepC |=> stA == 3'h1)
        else $error("first section did not restart its count");
    div_states_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        stA != 3'h7 && stD != 3'h7)
        else $error("divider left its six-state cycle");
endmodule // fac_frame_address_countdown

// ### sim/fac_skip_partner.sv
`timescale 1ns/10ps
// downstream address detector: asks for one skip at each address-1 rise
module fac_skip_partner (
    input wire logic clk_sys, // system clock
    input wire logic resetn, // synchronous reset, active low
    input wire logic addressSeparationMode, // separation mode level
    input wire logic enable, // bench lets skips through
    input wire logic frameAddressOne, // address-1 from the block
    output logic skipRequest, // one-cycle skip request
    output int skipCount // skips issued so far
);
    logic addrPrev_ff;
    logic addrRise;
    assign addrRise = frameAddressOne && !addrPrev_ff;
    always_ff @(posedge clk_sys)
    begin
        addrPrev_ff <= frameAddressOne;
        skipRequest <= 1'b0;
        if (!resetn)
            skipCount <= 0;
        else if (enable && addressSeparationMode && addrRise)
        begin
            skipRequest <= 1'b1;
            skipCount <= skipCount + 1;
        end
    end
endmodule // fac_skip_partner

// ### sim/fac_frame_address_countdown_test.sv
`timescale 1ns/10ps
module fac_frame_address_countdown_test;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic countdownPulse = 1'b0;
    logic addressSeparationMode = 1'b0;
    logic timingOneCtl = 1'b0;
    logic timingTwoCtl = 1'b0;
    logic skipEnable = 1'b0;
    logic skipRequest, controlPulse, trafficTimingOne, trafficTimingTwo;
    logic timingOutOne, samplePhaseA, timingOutTwo, samplePhaseB;
    logic frameAddressOne, frameAddressTwo, prevWave, prevAddr, addrSeen;
    int miscompares = 0;
    int testsRun = 0;
    int cyc = 0;
    int armAt = 1 << 30;
    int waveAt = -1;
    int ctlSeen, ctlSince, skipCount, s0, p;
    int qCtl[$], qOne[$], qTwo[$];
    wire [8:0] allOut = {controlPulse, trafficTimingOne, trafficTimingTwo,
        timingOutOne, samplePhaseA, timingOutTwo, samplePhaseB,
        frameAddressOne, frameAddressTwo};

    fac_frame_address_countdown i_fac_frame_address_countdown (
        .clk_sys(clk_sys), .resetn(resetn), .countdownPulse(countdownPulse),
        .skipRequest(skipRequest),
        .addressSeparationMode(addressSeparationMode),
        .timingOneCtl(timingOneCtl), .timingTwoCtl(timingTwoCtl),
        .controlPulse(controlPulse), .trafficTimingOne(trafficTimingOne),
        .trafficTimingTwo(trafficTimingTwo), .timingOutOne(timingOutOne),
        .samplePhaseA(samplePhaseA), .timingOutTwo(timingOutTwo),
        .samplePhaseB(samplePhaseB), .frameAddressOne(frameAddressOne),
        .frameAddressTwo(frameAddressTwo));
    fac_skip_partner i_fac_skip_partner (
        .clk_sys(clk_sys), .resetn(resetn), .enable(skipEnable),
        .addressSeparationMode(addressSeparationMode),
        .frameAddressOne(frameAddressOne), .skipRequest(skipRequest),
        .skipCount(skipCount));

    task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
        testsRun++;
        if (got !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic stopTest();
        $display("compares %0d mismatches %0d", testsRun, miscompares);
        if (miscompares == 0 && testsRun > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // the first pulse of a train has no measured period, so its echo is
    // left unchecked and checking arms from the second pulse
    task automatic train(input int n, input bit timed, input bit skips);
        for (int k = 0; k < n; k++)
        begin
            // skips start with the second pulse so every deletion is counted
            skipEnable = skips && k > 0 && k < n - 4;
            if (k == 1)
                armAt = cyc + 3;
            if (timed && k > 0)
            begin
                qCtl.push_back(cyc + 3);
                qCtl.push_back(cyc + 3 + p / 2);
            end
            countdownPulse = 1'b1;
            @(posedge clk_sys);
            #2 countdownPulse = 1'b0;
            repeat (p - 1) @(posedge clk_sys);
            #2;
        end
        armAt = 1 << 30;
    endtask

    task automatic waves(input int n);
        timingTwoCtl = 1'b1;
        qTwo.push_back(cyc + 3);
        for (int k = 0; k < n; k++)
        begin
            repeat (8 + $urandom % 20) @(posedge clk_sys);
            #2 timingOneCtl = ~timingOneCtl;
            timingTwoCtl = ~timingOneCtl;
            if (timingOneCtl)
                qOne.push_back(cyc + 3);
            else
                qTwo.push_back(cyc + 3);
        end
        repeat (8) @(posedge clk_sys);
        #2;
    endtask

    initial
    begin
        forever #20 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys)
    begin
        cyc <= cyc + 1;
        if (cyc == 60000)
        begin
            miscompares++;
            stopTest();
        end
    end

    always @(negedge clk_sys)
    begin
        if (!addressSeparationMode)
        begin
            ctlSince = 0;
            addrSeen = 1'b0;
        end
        if (controlPulse && cyc >= armAt)
            ctlSeen++;
        if (controlPulse && cyc >= armAt && qCtl.size() > 0)
            cmp(cyc, qCtl.pop_front());
        if (cyc == waveAt)
            cmp({trafficTimingOne, trafficTimingTwo}, 2'h2 >> prevWave);
        if (controlPulse && addressSeparationMode)
        begin
            ctlSince++;
            prevWave = trafficTimingOne;
            waveAt = cyc + 1;
        end
        // the first toggle after mode entry depends on divider phase
        if (resetn && frameAddressOne !== prevAddr)
        begin
            if (addrSeen)
                cmp(ctlSince, 72);
            cmp(frameAddressTwo, !frameAddressOne);
            ctlSince = 0;
            addrSeen = 1'b1;
        end
        prevAddr = frameAddressOne;
        if (timingOutOne)
            cmp(cyc, qOne.pop_front());
        if (timingOutOne)
            cmp(samplePhaseA, 1'b1);
        if (timingOutTwo)
            cmp({cyc, samplePhaseB}, {qTwo.pop_front(), 1'b1});
    end

    initial
    begin
        void'($urandom(35645));
        repeat (3) @(posedge clk_sys);
        #2 cmp(allOut, 9'h041);
        resetn = 1'b1;
        p = 32 + 2 * ($urandom % 16);
        train(40, 1'b0, 1'b1);
        cmp({trafficTimingOne, frameAddressOne, frameAddressTwo}, 3'h1);
        $display("test mode off done");
        addressSeparationMode = 1'b1;
        p = 32 + 2 * ($urandom % 16);
        train(200, 1'b1, 1'b0);
        cmp(qCtl.size(), 0);
        $display("test doubling done");
        p = 32 + 2 * ($urandom % 16);
        s0 = skipCount;
        ctlSeen = 0;
        train(400, 1'b0, 1'b1);
        cmp(ctlSeen, 798 - (skipCount - s0));
        cmp(skipCount - s0 > 0, 1);
        $display("test skip done");
        waves(30);
        cmp(qOne.size() + qTwo.size(), 0);
        $display("test timing outputs done");
        stopTest();
    end
endmodule // fac_frame_address_countdown_test
